// File: src/lfttim_pkg.sv
// Notes on behaviour
// R01 - 16-bit timer counts up each slow clock
// R02 - run bit off stops and zeroes timer
// R03 - writing capture trigger latches timer value
// R04 - fine counter counts fast cycles since slow edge
// R05 - fine capture drops counter least significant bit
// R06 - radio edge captures only when enabled
// R07 - mode 11 interrupts on match, clears timer
// R08 - mode 10 interrupts, timer wraps; 0x disabled
// R09 - compare is high:low bytes, reset 0xFF
// R10 - compare byte writes take effect immediately
// R11 - mode 11 period is compare plus one
// R12 - first interrupt may come up to one tick early
// R13 - pre-start lead 49 crystal, 2 RC only
// R14 - RC oscillator clocks pre-start when enabled
// R15 - crystal kept in retention uses short lead
// R16 - software keeps retention interval above lead
// R17 - software enables a slow clock source first
// R18 - software masks interrupt while rewriting compare
// R19 - software masks radio until captures read
// R20 - wakeup interrupt is a rising-edge pulse
// R21 - simultaneous triggers give one single capture
package lfttim_pkg;
  localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
  localparam int unsigned SLOW_FREQ_HZ   = 32_768;
  localparam int unsigned TIMER_W        = 16;
  localparam int unsigned FINE_W         = 9;
  localparam int unsigned SFR_AW         = 8;
  localparam int unsigned SFR_DW         = 8;

  localparam logic [7:0] ADDR_CAPT_HI    = 8'hAB;
  localparam logic [7:0] ADDR_FINE_CAPT  = 8'hAC;
  localparam logic [7:0] ADDR_CONTROL    = 8'hB3;
  localparam logic [7:0] ADDR_CMP_LO     = 8'hB4;
  localparam logic [7:0] ADDR_CMP_HI     = 8'hB5;
  localparam logic [7:0] ADDR_CAPT_LO    = 8'hB6;

  localparam int unsigned BIT_RUN        = 0;
  localparam int unsigned BIT_MODE_LO    = 1;
  localparam int unsigned BIT_MODE_HI    = 2;
  localparam int unsigned BIT_RADIO_EN   = 3;
  localparam int unsigned BIT_SW_CAPT    = 4;

  localparam logic [1:0] MODE_RESET_ON_MATCH = 2'h3;
  localparam logic [1:0] MODE_FREE_MATCH     = 2'h2;

  localparam logic [7:0] CMP_RESET       = 8'hFF;
  localparam logic [7:0] CAPT_RESET      = 8'h00;
  localparam logic [7:0] CTRL_RESET      = 8'h00;

  localparam logic [15:0] LEAD_LONG      = 16'h0031;
  localparam logic [15:0] LEAD_SHORT     = 16'h0002;
endpackage : lfttim_pkg

// File: src/lfttim_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module lfttim_sync_edge (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic meta;
  logic last;

  // meta feeds only the second stage
  always_ff @(posedge clock) begin
    if (srst) begin
      meta  <= 1'b0;
      level <= 1'b0;
      last  <= 1'b0;
      rise  <= 1'b0;
    end else begin
      meta  <= async_in;
      level <= meta;
      last  <= level;
      rise  <= level & ~last;
    end
  end
endmodule : lfttim_sync_edge
`default_nettype wire

// File: src/lfttim_top.sv
`timescale 1ns/1ps
`default_nettype none
module lfttim_top #(
  parameter int unsigned FINE_WIDTH = lfttim_pkg::FINE_W
) (
  input  wire logic                     clock,
  input  wire logic                     srst,
  input  wire logic                     slow_clock,
  input  wire logic                     radio_irq,
  input  wire logic [lfttim_pkg::SFR_AW-1:0] sfr_addr,
  input  wire logic                     sfr_wr_en,
  input  wire logic [lfttim_pkg::SFR_DW-1:0] sfr_wdata,
  input  wire logic                     sfr_rd_en,
  output logic [lfttim_pkg::SFR_DW-1:0] sfr_rdata,
  input  wire logic                     retention_mode,
  input  wire logic                     crystal_osc_fast_en,
  input  wire logic                     rc_osc_fast_en,
  input  wire logic                     crystal_kept_in_retention,
  output logic                          wakeup_irq,
  output logic                          prestart_wake,
  output logic                          prestart_use_rc
);
  import lfttim_pkg::*;

  logic [7:0]            ctrl;
  logic [7:0]            cmp_lo;
  logic [7:0]            cmp_hi;
  logic [7:0]            capt_lo;
  logic [7:0]            capt_hi;
  logic [7:0]            fine_capt;
  logic [TIMER_W-1:0]    timer;
  logic [FINE_WIDTH-1:0] fine_cnt;
  logic                  slow_tick;
  logic                  radio_edge;

  lfttim_sync_edge u_slow_sync (
    .clock    (clock),
    .srst     (srst),
    .async_in (slow_clock),
    .level    (),
    .rise     (slow_tick)
  );

  lfttim_sync_edge u_radio_sync (
    .clock    (clock),
    .srst     (srst),
    .async_in (radio_irq),
    .level    (),
    .rise     (radio_edge)
  );

  function automatic logic sel(input logic [7:0] a, input logic [7:0] b);
    sel = (a == b);
  endfunction : sel

  // register decode
  wire                wr_ctrl    = sfr_wr_en && sel(sfr_addr, ADDR_CONTROL);
  wire                wr_cmp_lo  = sfr_wr_en && sel(sfr_addr, ADDR_CMP_LO);
  wire                wr_cmp_hi  = sfr_wr_en && sel(sfr_addr, ADDR_CMP_HI);
  wire                run        = ctrl[BIT_RUN];
  wire [1:0]          match_mode = ctrl[BIT_MODE_HI:BIT_MODE_LO];
  wire                radio_en   = ctrl[BIT_RADIO_EN];
  wire [TIMER_W-1:0]  cmp_value  = {cmp_hi, cmp_lo};                       // [R09]
  wire                sw_capture = wr_ctrl && sfr_wdata[BIT_SW_CAPT];      // [R03]
  wire                radio_capt = radio_edge && radio_en;                 // [R06]
  // either source, or both together, makes one capture
  wire                capture    = sw_capture || radio_capt;               // [R21]
  wire                mode_on    = match_mode[1];                          // [R08]
  wire                match_hit  = run && slow_tick && mode_on && (timer == cmp_value);
  wire                clear_hit  = match_hit && (match_mode == MODE_RESET_ON_MATCH);
  wire [TIMER_W-1:0]  remaining  = cmp_value - timer;
  wire                use_short  = !crystal_osc_fast_en || crystal_kept_in_retention; // [R15]
  wire [TIMER_W-1:0]  lead       = use_short ? LEAD_SHORT : LEAD_LONG;     // [R13]
  // the match fires one period after timer reaches compare, so strict less-than gives the lead
  wire                near_match = run && mode_on && retention_mode &&
                                   (timer <= cmp_value) && (remaining < lead);
  wire                fine_max   = &fine_cnt;
  wire [7:0]          fine_trunc = fine_cnt[FINE_WIDTH-1 -: 8];            // [R05]

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (sfr_addr)
      ADDR_CONTROL:   next_rdata = {4'h0, ctrl[3:0]};
      ADDR_CMP_LO:    next_rdata = cmp_lo;
      ADDR_CMP_HI:    next_rdata = cmp_hi;
      ADDR_CAPT_LO:   next_rdata = capt_lo;
      ADDR_CAPT_HI:   next_rdata = capt_hi;
      ADDR_FINE_CAPT: next_rdata = fine_capt;
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd_en) begin
      sfr_rdata <= next_rdata;
    end
  end

  // trigger bit is write-only, never stored
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= {4'h0, sfr_wdata[3:0]};
    end
  end

  // each byte write updates the compare at once; a half-written value can match
  always_ff @(posedge clock) begin
    if (srst) begin
      cmp_lo <= CMP_RESET;                                                 // [R09]
      cmp_hi <= CMP_RESET;
    end else begin
      if (wr_cmp_lo) cmp_lo <= sfr_wdata;                                  // [R10]
      if (wr_cmp_hi) cmp_hi <= sfr_wdata;                                  // [R10]
    end
  end

  // period is cmp+1 ticks in clear mode; start phase vs slow edge gives one tick of slack
  always_ff @(posedge clock) begin
    if (srst || !run) begin
      timer <= '0;                                                         // [R02]
    end else if (clear_hit) begin
      timer <= '0;                                                         // [R07] [R11]
    end else if (slow_tick) begin
      timer <= timer + 1'b1;                                               // [R01] [R08] [R12]
    end
  end

  // saturates so a long gap never wraps to a small false count
  always_ff @(posedge clock) begin
    if (srst || slow_tick) begin
      fine_cnt <= '0;                                                      // [R04]
    end else if (!fine_max) begin
      fine_cnt <= fine_cnt + 1'b1;                                         // [R04]
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      capt_lo   <= CAPT_RESET;
      capt_hi   <= CAPT_RESET;
      fine_capt <= CAPT_RESET;
    end else if (capture) begin
      capt_lo   <= timer[7:0];                                             // [R03]
      capt_hi   <= timer[15:8];                                            // [R03]
      fine_capt <= fine_trunc;                                             // [R04] [R05]
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wakeup_irq      <= 1'b0;
      prestart_wake   <= 1'b0;
      prestart_use_rc <= 1'b0;
    end else begin
      wakeup_irq      <= match_hit;                                        // [R07] [R20]
      prestart_wake   <= near_match && !match_hit;                         // [R13]
      prestart_use_rc <= near_match && !match_hit && rc_osc_fast_en;       // [R14]
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_off_zero;
    !run |=> timer == '0;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("timer not held at zero"); // [R02]

  property p_count_up;
    run && slow_tick && !clear_hit && $past(run) |=> timer == $past(timer) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("timer did not step"); // [R01]

  property p_hold;
    run && !slow_tick && !clear_hit |=> $stable(timer);
  endproperty
  a_hold: assert property (p_hold) else $error("timer moved without tick"); // [R01]

  property p_sw_capt;
    sw_capture |=> {capt_hi, capt_lo} == $past(timer);
  endproperty
  a_sw_capt: assert property (p_sw_capt) else $error("coarse capture wrong"); // [R03]

  property p_fine_capt;
    capture |=> fine_capt == $past(fine_cnt[FINE_WIDTH-1:1]);
  endproperty
  a_fine_capt: assert property (p_fine_capt) else $error("fine capture wrong"); // [R05]

  property p_radio_off;
    radio_edge && !radio_en && !sw_capture |=> $stable({capt_hi, capt_lo, fine_capt});
  endproperty
  a_radio_off: assert property (p_radio_off) else $error("disabled radio captured"); // [R06]

  property p_clear;
    match_hit && match_mode == MODE_RESET_ON_MATCH |=> timer == '0 && wakeup_irq;
  endproperty
  a_clear: assert property (p_clear) else $error("match did not clear timer"); // [R07]

  property p_wrap;
    match_hit && match_mode == MODE_FREE_MATCH |=> wakeup_irq && timer == $past(timer) + 16'h0001;
  endproperty
  a_wrap: assert property (p_wrap) else $error("free mode match wrong"); // [R08]

  property p_no_irq;
    !mode_on |=> !wakeup_irq;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq while compare off"); // [R08]

  property p_irq_pulse;
    wakeup_irq |=> !wakeup_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse"); // [R20]

  property p_cmp_now;
    wr_cmp_lo |=> cmp_lo == $past(sfr_wdata) && $stable(cmp_hi) || $past(wr_cmp_hi);
  endproperty
  a_cmp_now: assert property (p_cmp_now) else $error("compare byte not applied"); // [R10]

  property p_prestart;
    retention_mode && $past(retention_mode) && $past(run) && timer == cmp_value && run
      && mode_on && !slow_tick |=> prestart_wake;
  endproperty
  a_prestart: assert property (p_prestart) else $error("no pre-start before irq"); // [R13]

  c_periodic: cover property (wakeup_irq && match_mode == MODE_RESET_ON_MATCH);
  c_radio:    cover property (radio_capt && !sw_capture);
  c_both:     cover property (radio_capt && sw_capture);
  c_prestart: cover property (prestart_wake && prestart_use_rc);
endmodule : lfttim_top
`default_nettype wire

// File: test/lfttim_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module lfttim_far_end #(
  parameter int unsigned SLOW_HALF_NS = 100
) (
  input  wire logic radio_fire,
  output logic      slow_clock,
  output logic      radio_irq
);
  // slow source runs before the timer is used; short period keeps the run brief
  initial slow_clock = 1'b0;
  always #(SLOW_HALF_NS) slow_clock = ~slow_clock;
  // radio line held high long enough for the synchroniser to see the edge
  initial radio_irq = 1'b0;
  always @(posedge radio_fire) begin
    radio_irq = 1'b1;
    #50 radio_irq = 1'b0;
  end
endmodule : lfttim_far_end
`default_nettype wire

// File: test/lfttim_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lfttim_top_tb;
  import lfttim_pkg::*;
  localparam int SP = 40; // slow period in fast cycles
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       radio_fire = 1'b0;
  logic       slow_clock;
  logic       radio_irq;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr_en = 1'b0;
  logic       sfr_rd_en = 1'b0;
  logic [7:0] sfr_rdata;
  logic       retention_mode = 1'b0;
  logic       crystal_osc_fast_en = 1'b0;
  logic       rc_osc_fast_en = 1'b0;
  logic       crystal_kept_in_retention = 1'b0;
  logic       wakeup_irq;
  logic       prestart_wake;
  logic       prestart_use_rc;
  int         err_count = 0;
  int         samples_checked = 0;
  int         t;
  logic [7:0] d;
  always #2.5 clock = ~clock;
  lfttim_far_end far_end (.radio_fire(radio_fire), .slow_clock(slow_clock),
    .radio_irq(radio_irq));
  lfttim_top dut (
    .clock(clock), .srst(srst), .slow_clock(slow_clock), .radio_irq(radio_irq),
    .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata),
    .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata), .retention_mode(retention_mode),
    .crystal_osc_fast_en(crystal_osc_fast_en), .rc_osc_fast_en(rc_osc_fast_en),
    .crystal_kept_in_retention(crystal_kept_in_retention), .wakeup_irq(wakeup_irq),
    .prestart_wake(prestart_wake), .prestart_use_rc(prestart_use_rc));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  // wait for a slow rise, then sit well clear of the synchronised tick
  task automatic mid_slow(input int k);
    repeat (k) @(posedge slow_clock);
    step(20);
  endtask : mid_slow
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr_en = 1'b1;
    step(1);
    sfr_wr_en = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr = a;
    sfr_rd_en = 1'b1;
    step(1);
    sfr_rd_en = 1'b0;
    v = sfr_rdata;
    step(1);
  endtask : rd
  task automatic fire();
    radio_fire = 1'b1;
    step(10);
    radio_fire = 1'b0;
  endtask : fire
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (wakeup_irq !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    if (n < lim) begin
      step(1);
      chk("irq width", {15'h0, wakeup_irq}, 16'h0000);
    end
  endtask : wait_irq
  task automatic t_reset();
    logic [7:0] a [7] = '{ADDR_CAPT_HI, ADDR_FINE_CAPT, ADDR_CONTROL, ADDR_CMP_LO,
                          ADDR_CMP_HI, ADDR_CAPT_LO, 8'h00};
    logic [7:0] e [7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
    wr(ADDR_CAPT_HI, 8'h5A);
    for (int i = 0; i < 7; i++) begin
      rd(a[i], d);
      chk("reset value", {8'h00, d}, {8'h00, e[i]});
    end
  endtask : t_reset
  task automatic t_capture();
    mid_slow(1);
    wr(ADDR_CONTROL, 8'h01);
    mid_slow(5);
    wr(ADDR_CONTROL, 8'h11);
    rd(ADDR_CAPT_LO, d);
    chk("capture low", {8'h00, d}, 16'h0005);
    rd(ADDR_CAPT_HI, d);
    chk("capture high", {8'h00, d}, 16'h0000);
    rd(ADDR_FINE_CAPT, d);
    chk("fine window", 16'(d >= 8'h07 && d <= 8'h0A), 16'h0001);
    rd(ADDR_CONTROL, d);
    chk("control", {8'h00, d}, 16'h0001);
    wr(ADDR_CONTROL, 8'h00);
    mid_slow(2);
    wr(ADDR_CONTROL, 8'h10);
    rd(ADDR_CAPT_LO, d);
    chk("held timer", {8'h00, d}, 16'h0000);
    wr(ADDR_CONTROL, 8'h09);
    mid_slow(3);
    fire();
    rd(ADDR_CAPT_LO, d);
    chk("radio capture", {8'h00, d}, 16'h0003);
    wr(ADDR_CONTROL, 8'h01);
    mid_slow(2);
    fire();
    rd(ADDR_CAPT_LO, d);
    chk("radio off", {8'h00, d}, 16'h0003);
    wr(ADDR_CONTROL, 8'h09);
    mid_slow(1);
    // radio edge lands three edges after the pin, same edge as the write below
    radio_fire = 1'b1;
    step(3);
    wr(ADDR_CONTROL, 8'h19);
    radio_fire = 1'b0;
    rd(ADDR_CAPT_LO, d);
    chk("joint capture", {8'h00, d}, 16'h0006);
  endtask : t_capture
  task automatic t_modes();
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CMP_HI, 8'h00);
    wr(ADDR_CMP_LO, 8'h03);
    wr(ADDR_CONTROL, 8'h07);
    wait_irq(9000, t);
    wait_irq(9000, t);
    chk("period 4", 16'(t + 1), 16'(4 * SP));
    // timer is zero right after the pulse, so one byte alone must shorten the period
    wr(ADDR_CMP_LO, 8'h01);
    wait_irq(9000, t);
    chk("period 2", 16'(t + 3), 16'(2 * SP));
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CMP_LO, 8'h03);
    wr(ADDR_CONTROL, 8'h05);
    wait_irq(9000, t);
    mid_slow(2);
    wr(ADDR_CONTROL, 8'h15);
    rd(ADDR_CAPT_LO, d);
    chk("no clear", {8'h00, d}, 16'h0006);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, 8'(2 * m + 1));
      wait_irq(8 * SP, t);
      chk("no irq", 16'(t), 16'(8 * SP));
    end
  endtask : t_modes
  task automatic t_prestart();
    int         lead [3] = '{49, 2, 2};
    logic [2:0] cfg [3] = '{3'b100, 3'b010, 3'b101};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CONTROL, 8'h00);
      {crystal_osc_fast_en, rc_osc_fast_en, crystal_kept_in_retention} = cfg[i];
      retention_mode = 1'b1;
      wr(ADDR_CMP_LO, 8'h40);
      wr(ADDR_CONTROL, 8'h07);
      t = 0;
      while (prestart_wake !== 1'b1 && t < 4000) begin
        step(1);
        t++;
      end
      chk("rc select", {15'h0, prestart_use_rc}, {15'h0, rc_osc_fast_en});
      wait_irq(4000, t);
      chk("lead", 16'(t >= lead[i] * SP - 2 && t <= lead[i] * SP + 2), 16'h0001);
      retention_mode = 1'b0;
    end
  endtask : t_prestart
  initial begin
    step(2);
    srst = 1'b0;
    t_reset();
    t_capture();
    t_modes();
    t_prestart();
    print_verdict();
  end
  initial begin
    #150000;
    err_count++;
    print_verdict();
  end
endmodule : lfttim_top_tb
`default_nettype wire
